// [bench/ocs_bus_master.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Serial bus master model; SCL rests high between frames
module ocs_bus_master (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    logic lclk; // 12 ns timing base
    initial begin lclk = 1'b0; #5; forever #6 lclk = ~lclk; end
    initial begin scl_out = 1'b1; sda_low_out = 1'b0; end
    task automatic w(input int n); repeat (n) @(posedge lclk); endtask
    // SDA moves only with SCL low, one pulse a bit
    task automatic bit_io(input logic b, output logic s);
        w(5); sda_low_out = !b;
        w(20); scl_out = 1'b1;
        w(10); s = sda_in;
        w(10); scl_out = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        w(5); sda_low_out = 1'b0;
        w(20); scl_out = 1'b1;
        w(10); sda_low_out = 1'b1;
        w(10); scl_out = 1'b0;
    endtask
    // Stop leaves the bus idle
    task automatic stop();
        w(5); sda_low_out = 1'b1;
        w(20); scl_out = 1'b1;
        w(10); sda_low_out = 1'b0;
        w(20);
    endtask
    // MSB first, ninth bit released when rel
    task automatic xfer(input logic [7:0] tx, input logic rel,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin bit_io(tx[i], s); rx[i] = s; end
        bit_io(rel, s); ack = !s;
    endtask
endmodule
`default_nettype wire

// [bench/ocs_config_slave_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checker, reference clock domain
module ocs_config_slave_checker (
    input wire logic       ref_clk_in,
    input wire logic       arst_n_in,
    input wire logic       scl_clk_in,
    input wire logic       power_down_input_n_in,
    input wire logic       dither_enable_input_in,
    input wire logic       sda_oe_out,
    input wire logic       osc_enable_out,
    input wire logic       park_drive_low_out,
    input wire logic       park_float_out,
    input wire logic       dither_on_out,
    input wire logic       dither_deep_out,
    input wire logic [3:0] div_exp_out,
    input wire logic       nv_busy_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Busy window: held first, then bounded end
    sequence s_hold; nv_busy_out[*8]; endsequence
    sequence s_end; ##[0:1000] !nv_busy_out; endsequence
    property p_busy; $rose(nv_busy_out) |-> s_hold ##1 s_end; endproperty
    a_busy: assert property (p_busy) else $error("busy span bad");
    property p_quiet; nv_busy_out |-> !sda_oe_out; endproperty
    a_quiet: assert property (p_quiet) else $error("ack while busy");
    property p_sda; $changed(sda_oe_out) |-> !scl_clk_in; endproperty
    a_sda: assert property (p_sda) else $error("sda moved, scl high");
    property p_exp; div_exp_out <= 4'h8; endproperty
    a_exp: assert property (p_exp) else $error("exponent above 8");
    property p_deep; dither_deep_out |-> dither_on_out; endproperty
    a_deep: assert property (p_deep) else $error("depth w/o dither");
    property p_osc; $rose(power_down_input_n_in) |-> ##[1:5] osc_enable_out;
    endproperty
    a_osc: assert property (p_osc) else $error("osc not started");
    property p_dith; $fell(dither_enable_input_in) |-> ##[1:5] !dither_on_out;
    endproperty
    a_dith: assert property (p_dith) else $error("dither stuck");
    property p_park; !osc_enable_out && !$past(osc_enable_out) |->
        park_float_out ^ park_drive_low_out; endproperty
    a_park: assert property (p_park) else $error("park state bad");
endmodule
bind ocs_config_slave ocs_config_slave_checker ocs_config_slave_checker_i (
    .ref_clk_in, .arst_n_in, .scl_clk_in, .power_down_input_n_in,
    .dither_enable_input_in, .sda_oe_out, .osc_enable_out,
    .park_drive_low_out, .park_float_out, .dither_on_out,
    .dither_deep_out, .div_exp_out, .nv_busy_out);
`default_nettype wire

// [bench/osc_config_serial_slave_test.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Self-checking bench
module osc_config_serial_slave_test;
    logic       clk, rst_n, nv_n, pwr, dith, a;
    logic       scl, m_low, oe, osc, pk_lo, pk_fl, don, deep, busy, sdo;
    logic [3:0] dexp;
    logic [7:0] r, v, pre, ad;
    int         n_fail, compares;
    wire logic  sda = !((oe && !sdo) || m_low); // Pulled-up open drain
    ocs_config_slave #(.NV_WRITE_CYCLES(800)) ocs_config_slave_i (
        .ref_clk_in(clk), .arst_n_in(rst_n), .nv_arst_n_in(nv_n),
        .scl_clk_in(scl), .sda_in(sda), .power_down_input_n_in(pwr),
        .dither_enable_input_in(dith), .sda_out(sdo), .sda_oe_out(oe),
        .osc_enable_out(osc), .park_drive_low_out(pk_lo),
        .park_float_out(pk_fl), .dither_on_out(don),
        .dither_deep_out(deep), .div_exp_out(dexp), .nv_busy_out(busy));
    ocs_bus_master ocs_bus_master_i (.sda_in(sda), .scl_out(scl),
        .sda_low_out(m_low));
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    function automatic logic [7:0] exp_of(input logic [7:0] p);
        return (p[3:0] > 4'h8) ? 8'h08 : {4'h0, p[3:0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic put(input logic [7:0] b, input logic ea);
        ocs_bus_master_i.xfer(b, 1'b1, r, a);
        check(8'(a), 8'(ea));
    endtask
    task automatic wr(input logic [7:0] p, input int nd,
                      input logic [7:0] d, input logic eb);
        ocs_bus_master_i.start();
        put(ad, 1'b1);
        put(p, 1'b1);
        if (nd > 0) put(d, 1'b1);
        ocs_bus_master_i.stop();
        repeat (10) @(negedge clk);
        check(8'(busy), 8'(eb));
        if (eb) begin
            ocs_bus_master_i.start();
            put(ad, 1'b0);
            ocs_bus_master_i.stop();
        end
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
        check(8'(busy), 8'h00);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        ocs_bus_master_i.start();
        put(ad, 1'b1);
        put(p, 1'b1);
        ocs_bus_master_i.start();
        put(ad | 8'h01, 1'b1);
        ocs_bus_master_i.xfer(8'hFF, 1'b0, r, a);
        check(r, e);
        ocs_bus_master_i.xfer(8'hFF, 1'b1, r, a);
        check(r, e);
        @(negedge clk);
        check(8'(oe), 8'h00);
        ocs_bus_master_i.stop();
    endtask
    initial begin
        {rst_n, nv_n, dith, n_fail, compares} = '0;
        {pwr, ad, pre} = {1'b1, 8'hA0, 8'hC6};
        void'($urandom(32'hA2407CC3));
        repeat (5) @(negedge clk);
        {rst_n, nv_n} = 2'b11;
        repeat (10) @(negedge clk);
        rd(8'h02, pre);
        rd(8'h0D, 8'hF0);
        rd(8'h55, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h0F : 8'($urandom);
            wr(8'h02, 1, v, 1'b1);
            pre = v | 8'hC0;
            check({4'h0, dexp}, exp_of(pre));
            rd(8'h02, pre);
        end
        ocs_bus_master_i.start();
        put({4'hA, 3'h5, 1'b0}, 1'b0);
        ocs_bus_master_i.stop();
        wr(8'h0D, 1, 8'h0B, 1'b1);
        ad = 8'hA6;
        rd(8'h0D, 8'hFB);
        v = 8'($urandom);
        wr(8'h02, 1, v, 1'b0);
        pre = v | 8'hC0;
        wr(8'h3F, 0, 8'h00, 1'b1);
        {pwr, dith} = 2'b01;
        repeat (8) @(negedge clk);
        check({3'h0, osc, pk_lo, pk_fl, don, deep},
              {4'h0, pre[5], !pre[5], 1'b1, !pre[4]});
        {pwr, dith} = 2'b10;
        repeat (8) @(negedge clk);
        check({3'h0, osc, pk_lo, pk_fl, don, deep}, 8'h10);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        rd(8'h02, pre);
        rd(8'h0D, 8'hFB);
        complete_run();
    end
    // Hang guard, a little over twice the expected run
    initial begin
        #900000;
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire

// [src/ocs_config_slave.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ocs_regs.svh"

module ocs_config_slave #(
    // Fixed identifier nibble; value is arbitrary
    parameter logic [3:0] DEVICE_ID       = 4'hA,
    // Nonvolatile write time in reference clock cycles
    parameter int         NV_WRITE_CYCLES =
        `OCS_NV_WRITE_MS * `OCS_REF_CLK_KHZ
) (
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       nv_arst_n_in,
    input  wire logic       scl_clk_in,
    input  wire logic       sda_in,
    input  wire logic       power_down_input_n_in,
    input  wire logic       dither_enable_input_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            osc_enable_out,
    output logic            park_drive_low_out,
    output logic            park_float_out,
    output logic            dither_on_out,
    output logic            dither_deep_out,
    output logic [3:0]      div_exp_out,
    output logic            nv_busy_out
);

    // ======================================================
    // Constants
    // ======================================================
    localparam int CW = $clog2(NV_WRITE_CYCLES + 1);
    localparam logic [CW-1:0] NV_LOAD = CW'(NV_WRITE_CYCLES);

    // ======================================================
    // Functions
    // ======================================================

    // Exponent decode, anything past eight acts as eight
    function automatic logic [3:0] clamp_exp(
        input logic [3:0] raw
    );
        clamp_exp = (raw > `OCS_EXP_MAX) ? `OCS_EXP_MAX : raw;
    endfunction

    // Register readback by pointer
    function automatic logic [7:0] reg_read(
        input logic [7:0] ptr,
        input logic [7:0] pre,
        input logic [7:0] adr
    );
        case (ptr)
            `OCS_PTR_PRESCALE: reg_read = pre;
            `OCS_PTR_ADDRSEL:  reg_read = adr;
            default:           reg_read = `OCS_UNMAPPED;
        endcase
    endfunction

    // ======================================================
    // Pin synchronisers
    // ======================================================
    logic [3:0]        sync_w;   // Settled levels
    logic [3:0]        rise_w;   // Rising flags
    logic [3:0]        fall_w;   // Falling flags
    ocs_pkg::ocs_pins_s pins;    // Settled bundle
    ocs_pkg::ocs_pins_s rise;    // Rising bundle
    ocs_pkg::ocs_pins_s fall;    // Falling bundle

    ocs_pin_sync #(
        .WIDTH (4),
        // Bus lines idle high, control pins read as off
        .IDLE  (4'hC)
    ) u_sync (
        .clk_in    (ref_clk_in),
        .arst_n_in (arst_n_in),
        .async_in  ({scl_clk_in, sda_in, power_down_input_n_in,
                     dither_enable_input_in}),
        .sync_out  (sync_w),
        .rise_out  (rise_w),
        .fall_out  (fall_w)
    );

    assign pins = sync_w;
    assign rise = rise_w;
    assign fall = fall_w;

    // ======================================================
    // State
    // ======================================================
    ocs_pkg::ocs_state_e state_ff;     // Engine state
    ocs_pkg::ocs_state_e nxt_state;
    logic [3:0]    bit_cnt_ff;         // Bit within byte, 8=ack
    logic [3:0]    nxt_bit_cnt;
    logic [7:0]    shift_ff;           // Receive or send byte
    logic [7:0]    nxt_shift;
    logic [1:0]    byte_idx_ff;        // 0 addr, 1 ptr, 2 data
    logic [1:0]    nxt_byte_idx;
    logic          ack_ff;             // Current byte acknowledged
    logic          nxt_ack;
    logic          tx_mode_ff;         // Read direction latched
    logic          nxt_tx_mode;
    logic [7:0]    ptr_ff;             // Register pointer
    logic [7:0]    nxt_ptr;
    logic [7:0]    pre_ff;             // Divider and dither reg
    logic [7:0]    nxt_pre;
    logic [7:0]    adr_ff;             // Address and defer reg
    logic [7:0]    nxt_adr;
    logic          commit_ff;          // Commit awaiting stop
    logic          nxt_commit;
    logic          dirty_ff;           // Auto copy awaiting stop
    logic          nxt_dirty;
    logic          drive_ff;           // Pull SDA in next low
    logic          nxt_drive;
    logic          nv_start;           // Begin nonvolatile write
    logic [CW-1:0] busy_cnt_ff;        // Write time remaining
    logic [7:0]    nv_mem_ff [0:1];    // Nonvolatile copy
    logic          link_drive_ff;      // Link-side SDA pull

    // ======================================================
    // Bus events
    // ======================================================
    wire       start_ev = fall.sda & pins.scl;
    wire       stop_ev  = rise.sda & pins.scl;
    wire       scl_rise = rise.scl;
    wire [7:0] byte_in  = {shift_ff[6:0], pins.sda};
    wire       nv_busy  = (busy_cnt_ff != '0);
    wire [7:0] rd_data  = reg_read(ptr_ff, pre_ff, adr_ff);
    wire       defer    = adr_ff[`OCS_BIT_DEFER];
    // Identifier and select bits must match, never while busy
    wire       addr_hit = (byte_in[7:4] == DEVICE_ID) &&
                          (byte_in[3:1] == adr_ff[2:0]) &&
                          !nv_busy;
    wire       last_bit = (bit_cnt_ff == 4'h7);
    wire       ack_bit  = (bit_cnt_ff == 4'h8);

    // ======================================================
    // Protocol next state
    // ======================================================
    // Every bit moves on the settled SCL rise; the level to
    // drive in the following low phase is decided here, long
    // before the master lowers SCL, so the link flop can take
    // it on the falling edge.
    always_comb begin
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_byte_idx = byte_idx_ff;
        nxt_ack      = ack_ff;
        nxt_tx_mode  = tx_mode_ff;
        nxt_ptr      = ptr_ff;
        nxt_pre      = pre_ff;
        nxt_adr      = adr_ff;
        nxt_commit   = commit_ff;
        nxt_dirty    = dirty_ff;
        nxt_drive    = drive_ff;
        nv_start     = 1'b0;
        if (state_ff == ocs_pkg::OCS_ST_LOAD) begin
            // Pick up the stored settings once
            nxt_pre   = nv_mem_ff[0];
            nxt_adr   = nv_mem_ff[1];
            nxt_state = ocs_pkg::OCS_ST_IDLE;
        end else if (start_ev) begin
            // Start or repeated start opens a new frame
            nxt_state    = ocs_pkg::OCS_ST_RX;
            nxt_bit_cnt  = 4'h0;
            nxt_byte_idx = 2'h0;
            nxt_drive    = 1'b0;
        end else if (stop_ev) begin
            // Stop ends the frame and launches pending copies
            nxt_state = ocs_pkg::OCS_ST_IDLE;
            nxt_drive = 1'b0;
            if (commit_ff || dirty_ff) begin
                nv_start   = 1'b1;
                nxt_commit = 1'b0;
                nxt_dirty  = 1'b0;
            end
        end else if (scl_rise) begin
            unique case (state_ff)
                ocs_pkg::OCS_ST_LOAD,
                ocs_pkg::OCS_ST_IDLE: begin
                    // Not addressed, line left alone
                    nxt_drive = 1'b0;
                end
                ocs_pkg::OCS_ST_RX: begin
                    if (ack_bit) begin
                        // Acknowledge slot just sampled
                        nxt_bit_cnt = 4'h0;
                        if (!ack_ff) begin
                            nxt_state = ocs_pkg::OCS_ST_IDLE;
                            nxt_drive = 1'b0;
                        end else if (tx_mode_ff) begin
                            // First data bit out
                            nxt_state = ocs_pkg::OCS_ST_TX;
                            nxt_shift = rd_data;
                            nxt_drive = ~rd_data[7];
                        end else begin
                            nxt_drive = 1'b0;
                        end
                    end else if (last_bit) begin
                        // Whole byte in, choose acknowledge
                        nxt_shift   = byte_in;
                        nxt_bit_cnt = 4'h8;
                        if (byte_idx_ff != 2'h2) begin
                            nxt_byte_idx = byte_idx_ff + 2'h1;
                        end
                        unique case (byte_idx_ff)
                            2'h0: begin
                                nxt_ack     = addr_hit;
                                nxt_tx_mode = byte_in[0];
                            end
                            2'h1: begin
                                nxt_ack = 1'b1;
                                nxt_ptr = byte_in;
                                if (byte_in == `OCS_CMD_COMMIT) begin
                                    nxt_commit = 1'b1;
                                end
                            end
                            default: begin
                                nxt_ack = 1'b1;
                                if (ptr_ff == `OCS_PTR_PRESCALE) begin
                                    nxt_pre = byte_in |
                                        `OCS_PRE_ONES;
                                    // Defer set leaves it for commit
                                    if (!defer) begin
                                        nxt_dirty = 1'b1;
                                    end
                                end else if (ptr_ff ==
                                             `OCS_PTR_ADDRSEL) begin
                                    nxt_adr = byte_in |
                                        `OCS_ADR_ONES;
                                    nxt_dirty = 1'b1;
                                end
                            end
                        endcase
                        // Hold SDA low through the ninth pulse, for the address byte only on addr_hit
                        nxt_drive = (byte_idx_ff == 2'h0) ?
                                    addr_hit : 1'b1;
                    end else begin
                        // Shift one bit, MSB first
                        nxt_shift   = byte_in;
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                end
                ocs_pkg::OCS_ST_TX: begin
                    if (ack_bit) begin
                        // Master answer sampled
                        nxt_bit_cnt = 4'h0;
                        if (!pins.sda) begin
                            nxt_shift = rd_data;
                            nxt_drive = ~rd_data[7];
                        end else begin
                            // No acknowledge: let go for the stop
                            nxt_state = ocs_pkg::OCS_ST_IDLE;
                            nxt_drive = 1'b0;
                        end
                    end else if (last_bit) begin
                        // Release for the master acknowledge
                        nxt_bit_cnt = 4'h8;
                        nxt_drive   = 1'b0;
                    end else begin
                        nxt_shift   = {shift_ff[6:0], 1'b0};
                        nxt_drive   = ~shift_ff[6];
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Engine registers
    // ======================================================
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff    <= ocs_pkg::OCS_ST_LOAD;
            bit_cnt_ff  <= 4'h0;
            shift_ff    <= 8'h00;
            byte_idx_ff <= 2'h0;
            ack_ff      <= 1'b0;
            tx_mode_ff  <= 1'b0;
            ptr_ff      <= 8'h00;
            commit_ff   <= 1'b0;
            dirty_ff    <= 1'b0;
            drive_ff    <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            bit_cnt_ff  <= nxt_bit_cnt;
            shift_ff    <= nxt_shift;
            byte_idx_ff <= nxt_byte_idx;
            ack_ff      <= nxt_ack;
            tx_mode_ff  <= nxt_tx_mode;
            ptr_ff      <= nxt_ptr;
            commit_ff   <= nxt_commit;
            dirty_ff    <= nxt_dirty;
            drive_ff    <= nxt_drive;
        end
    end

    // Configuration registers, overwritten from storage
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_ff <= `OCS_PRE_DEFAULT;
            adr_ff <= `OCS_ADR_DEFAULT;
        end else begin
            pre_ff <= nxt_pre;
            adr_ff <= nxt_adr;
        end
    end

    // ======================================================
    // Nonvolatile store
    // ======================================================
    // Own reset stands for factory programming; the main reset
    // is a power cycle and must not touch it.
    always_ff @(posedge ref_clk_in or negedge nv_arst_n_in) begin
        if (!nv_arst_n_in) begin
            nv_mem_ff[0] <= `OCS_PRE_DEFAULT;
            nv_mem_ff[1] <= `OCS_ADR_DEFAULT;
        end else if (nv_start) begin
            // All registers copied together
            nv_mem_ff[0] <= pre_ff;
            nv_mem_ff[1] <= adr_ff;
        end
    end

    // Write time; requests are refused until it runs out
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_cnt_ff <= '0;
        end else if (nv_start) begin
            busy_cnt_ff <= NV_LOAD;
        end else if (nv_busy) begin
            busy_cnt_ff <= busy_cnt_ff - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // ======================================================
    // Link domain
    // ======================================================
    // SDA may only move while SCL is low, so the pull level
    // is taken on the SCL falling edge. drive_ff settles
    // within a few reference cycles of the rise and is stable
    // for the rest of the high phase (600 ns or more even at
    // 400 kHz), so this capture sees a quiet word.
    always_ff @(negedge scl_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_drive_ff <= 1'b0;
        end else begin
            link_drive_ff <= drive_ff;
        end
    end

    assign sda_oe_out = link_drive_ff;

    // ======================================================
    // Core control outputs
    // ======================================================
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sda_out            <= 1'b0;
            osc_enable_out     <= 1'b0;
            park_drive_low_out <= 1'b0;
            park_float_out     <= 1'b1;
            dither_on_out      <= 1'b0;
            dither_deep_out    <= 1'b0;
            div_exp_out        <= 4'h0;
            nv_busy_out        <= 1'b0;
        end else begin
            // Open drain: only ever pulls low
            sda_out            <= 1'b0;
            osc_enable_out     <= pins.run;
            park_drive_low_out <= !pins.run &&
                                  pre_ff[`OCS_BIT_PARK];
            park_float_out     <= !pins.run &&
                                  !pre_ff[`OCS_BIT_PARK];
            dither_on_out      <= pins.dith;
            dither_deep_out    <= pins.dith &&
                                  !pre_ff[`OCS_BIT_DEPTH];
            div_exp_out        <= clamp_exp(pre_ff[3:0]);
            nv_busy_out        <= nv_busy;
        end
    end

endmodule

`default_nettype wire

// [src/ocs_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Two-stage synchroniser with edge flags
// ==========================================================
module ocs_pin_sync #(
    parameter int               WIDTH = 4,
    // Level each line takes in reset, its idle level
    parameter logic [WIDTH-1:0] IDLE  = '1
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);

    logic [WIDTH-1:0] meta_ff;   // First stage, read by stage two only
    logic [WIDTH-1:0] sync_ff;   // Settled level
    logic [WIDTH-1:0] last_ff;   // Previous settled level

    // Reset to each line's idle level, so no false start,
    // stop or control pulse shows right after release
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_ff <= IDLE;
            sync_ff <= IDLE;
            last_ff <= IDLE;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // Edges compare settled stages only
    assign sync_out = sync_ff;
    assign rise_out = sync_ff & ~last_ff;
    assign fall_out = ~sync_ff & last_ff;

endmodule

`default_nettype wire

// [src/ocs_pkg.sv]
package ocs_pkg;

    // ======================================================
    // Protocol engine states, one-hot
    // ======================================================
    typedef enum logic [3:0] {
        OCS_ST_LOAD = 4'h1,  // Restore from nonvolatile copy
        OCS_ST_IDLE = 4'h2,  // Not addressed
        OCS_ST_RX   = 4'h4,  // Receiving bytes
        OCS_ST_TX   = 4'h8   // Sending bytes
    } ocs_state_e;

    // ======================================================
    // Synchronised pin bundle
    // ======================================================
    typedef struct packed {
        logic scl;     // Serial clock level
        logic sda;     // Serial data level
        logic run;     // Oscillator run request
        logic dith;    // Dither enable
    } ocs_pins_s;

endpackage

// [src/ocs_regs.svh]
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

// ==========================================================
// Register pointers and command code
// ==========================================================
`define OCS_PTR_PRESCALE  8'h02
`define OCS_PTR_ADDRSEL   8'h0D
`define OCS_CMD_COMMIT    8'h3F

// ==========================================================
// Field positions
// ==========================================================
`define OCS_BIT_PARK      5
`define OCS_BIT_DEPTH     4
`define OCS_BIT_DEFER     3

// ==========================================================
// Reset values and read-as-one masks
// ==========================================================
`define OCS_PRE_DEFAULT   8'hC6
`define OCS_ADR_DEFAULT   8'hF0
`define OCS_PRE_ONES      8'hC0
`define OCS_ADR_ONES      8'hF0
`define OCS_EXP_MAX       4'h8
`define OCS_UNMAPPED      8'hFF

// ==========================================================
// Timing
// ==========================================================
`define OCS_NV_WRITE_MS   10
`define OCS_REF_CLK_KHZ   100000

`endif
